// ===== servo_od_bank.sv
/*
 * Object-dictionary bank of the servo drive: loop gains with deferred
 * transfer, fixed readouts, voltage fault detection, analog reading,
 * encoder calibration sequencing and the present-fault entry.
 * Assumes the CANopen stack presents one entry access at a time on the
 * od_* port, synchronous to ref_clk, and that all inputs are synchronous.
 */
// Summary of operation
// RL1: the link runs at one megabit per second, ten drive clocks a bit.
// RL2: after reset the node identifier is 0x28 until it is reconfigured.
// RL3: gain writes reach the active loops only while the drive is disabled.
// RL4: integral gains are written unscaled and scaled here by sample rate.
// RL5: the signed temperature entry always reads zero.
// RL6: the pwm frequency entry reports the center-aligned switching rate.
// RL7: command 0 does nothing, 1 starts calibration, 2 starts alignment.
// RL8: calibration errors sit one per bit from bit 8 to bit 11.
// RL9: supply above the over-voltage threshold raises a fault; here it trips only above 37072 mV while the entry reads 37.0 V.
// RL10: supply below the under-voltage threshold raises a fault.
// RL11: the analog entry holds the latest conversion in millivolts.
// RL12: the fault entry shows present faults, encoder fault on bit 9.
// RL13: the drive is enabled only in operation-enabled status.
// RL14: writes to read-only entries are ignored, undefined bits read zero.
// RL15: gains written while enabled wait and apply once enable drops.
`timescale 1ns/1ps

module servo_od_bank #(
    parameter logic [31:0] PWM_FREQ_HZ   = 32'h00004e20,
    parameter logic [31:0] OV_THRESH_FLT = 32'h42140000,
    parameter logic [31:0] UV_THRESH_FLT = 32'h41100000,
    parameter logic [15:0] OV_MV         = 16'h90d0,
    parameter logic [15:0] UV_MV         = 16'h2328,
    parameter logic [7:0]  SAMPLE_SHIFT  = 8'h0d
) (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [15:0] od_index,
    input  wire logic        od_rd,
    input  wire logic        od_wr,
    input  wire logic [31:0] od_wdata,
    output logic      [31:0] od_rdata_q,
    output logic             od_ack_q,
    output logic             od_err_q,
    input  wire logic        node_id_load,
    input  wire logic [7:0]  node_id_new,
    output logic      [7:0]  node_id_q,
    output logic             can_bit_tick_q,
    input  wire logic [15:0] statusword,
    output logic             drive_enabled_q,
    output logic      [31:0] pos_ki_q,
    output logic      [31:0] pos_kp_q,
    output logic      [31:0] vel_ki_q,
    output logic      [31:0] vel_kp_q,
    input  wire logic        supply_valid,
    input  wire logic [15:0] supply_mv,
    output logic             ov_fault_q,
    output logic             uv_fault_q,
    input  wire logic        adc_valid,
    input  wire logic [15:0] adc_mv,
    input  wire logic        encoder_fault,
    output logic             cal_start_q,
    output logic             align_start_q,
    input  wire logic        cal_done,
    input  wire logic [3:0]  cal_errors
);

    logic [3:0]                bit_cnt_q;
    logic [31:0]               wr_gain_q  [0:3];
    logic [31:0]               act_gain_q [0:3];
    logic [3:0]                pend_q;
    logic [3:0]                gain_hit;
    logic                      en_now;
    logic [15:0]               analog_q;
    logic                      enc_fault_q;
    logic [15:0]               cal_cmd_q;
    logic [3:0]                cal_err_q;
    servo_od_pkg::cal_state_t  cal_state_q;
    logic                      cmd_wr;
    logic [15:0]               cal_status;
    logic [15:0]               fault_word;
    logic [31:0]               rd_val;
    logic                      rd_known;
    logic                      rd_only;

    // status bits other than 11:8, the documented error field, stay zero
    assign en_now = (statusword & servo_od_pkg::SW_ENABLED_MASK)
                    == servo_od_pkg::SW_ENABLED_VAL;              // see RL13
    assign cmd_wr = od_wr && od_index == servo_od_pkg::IDX_CAL_CMD;

    always_comb begin
        cal_status = 16'h0000;
        cal_status[servo_od_pkg::CAL_ERR_MSB:servo_od_pkg::CAL_ERR_LSB] =
            cal_err_q;                                            // see RL8
        fault_word = 16'h0000;
        fault_word[servo_od_pkg::FAULT_ENC_BIT] = enc_fault_q;    // see RL12
    end

    // multiplying by the sample period 2^-SAMPLE_SHIFT is an exponent
    // subtraction; values that would underflow flush to zero
    function automatic logic [31:0] scale_ki(input logic [31:0] g);
        logic [7:0] e;
        e = g[servo_od_pkg::FLT_EXP_MSB:servo_od_pkg::FLT_EXP_LSB];
        scale_ki = g;
        if (e <= SAMPLE_SHIFT) begin
            scale_ki = 32'h00000000;
        end else begin
            scale_ki[servo_od_pkg::FLT_EXP_MSB:servo_od_pkg::FLT_EXP_LSB] =
                e - SAMPLE_SHIFT;
        end
    endfunction

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            node_id_q <= servo_od_pkg::NODE_ID_RESET;             // see RL2
        end else if (node_id_load) begin
            node_id_q <= node_id_new;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            bit_cnt_q      <= 4'h0;
            can_bit_tick_q <= 1'b0;
        end else begin
            can_bit_tick_q <= bit_cnt_q == servo_od_pkg::BIT_CNT_MAX;
            if (bit_cnt_q == servo_od_pkg::BIT_CNT_MAX) begin     // see RL1
                bit_cnt_q <= 4'h0;
            end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            drive_enabled_q <= 1'b0;
        end else begin
            drive_enabled_q <= en_now;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < servo_od_pkg::GAIN_N; gi++) begin : g_gain
            assign gain_hit[gi] =
                od_wr && od_index == servo_od_pkg::GAIN_IDX[gi];
            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    wr_gain_q[gi]  <= servo_od_pkg::GAIN_RESET;
                    act_gain_q[gi] <= servo_od_pkg::GAIN_RESET;
                    pend_q[gi]     <= 1'b0;
                end else begin
                    if (gain_hit[gi]) begin
                        wr_gain_q[gi] <= od_wdata;
                    end
                    // a new write wins over the transfer in the same cycle
                    if (gain_hit[gi]) begin
                        pend_q[gi] <= 1'b1;                       // see RL15
                    end else if (pend_q[gi] && !en_now) begin     // see RL3
                        pend_q[gi] <= 1'b0;
                    end
                    if (pend_q[gi] && !en_now) begin
                        if (servo_od_pkg::GAIN_INT_MASK[gi]) begin // see RL4
                            act_gain_q[gi] <= scale_ki(wr_gain_q[gi]);
                        end else begin
                            act_gain_q[gi] <= wr_gain_q[gi];
                        end
                    end
                end
            end
        end
    endgenerate

    assign pos_ki_q = act_gain_q[0];
    assign pos_kp_q = act_gain_q[1];
    assign vel_ki_q = act_gain_q[2];
    assign vel_kp_q = act_gain_q[3];

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ov_fault_q <= 1'b0;
            uv_fault_q <= 1'b0;
        end else if (supply_valid) begin
            ov_fault_q <= supply_mv > OV_MV;                      // see RL9
            uv_fault_q <= supply_mv < UV_MV;                      // see RL10
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            analog_q    <= 16'h0000;
            enc_fault_q <= 1'b0;
        end else begin
            enc_fault_q <= encoder_fault;                         // see RL12
            if (adc_valid) begin
                analog_q <= adc_mv;                               // see RL11
            end
        end
    end

    // commands arriving while a sequence runs are stored but not started
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cal_state_q   <= servo_od_pkg::CAL_IDLE;
            cal_cmd_q     <= servo_od_pkg::CMD_NONE;
            cal_err_q     <= servo_od_pkg::CAL_ERR_RESET;
            cal_start_q   <= 1'b0;
            align_start_q <= 1'b0;
        end else begin
            cal_start_q   <= 1'b0;
            align_start_q <= 1'b0;
            if (cmd_wr) begin
                cal_cmd_q <= od_wdata[15:0];
            end else if (cal_done &&
                         cal_state_q != servo_od_pkg::CAL_IDLE) begin
                cal_cmd_q <= servo_od_pkg::CMD_NONE;
            end
            case (cal_state_q)
                servo_od_pkg::CAL_IDLE: begin
                    if (cmd_wr && od_wdata[15:0] ==
                        servo_od_pkg::CMD_CALIBRATE) begin        // see RL7
                        cal_state_q <= servo_od_pkg::CAL_RUN;
                        cal_start_q <= 1'b1;
                        cal_err_q   <= servo_od_pkg::CAL_ERR_RESET;
                    end else if (cmd_wr && od_wdata[15:0] ==
                        servo_od_pkg::CMD_ALIGN) begin            // see RL7
                        cal_state_q   <= servo_od_pkg::CAL_ALIGN;
                        align_start_q <= 1'b1;
                        cal_err_q     <= servo_od_pkg::CAL_ERR_RESET;
                    end
                end
                servo_od_pkg::CAL_RUN,
                servo_od_pkg::CAL_ALIGN: begin
                    if (cal_done) begin
                        cal_state_q <= servo_od_pkg::CAL_IDLE;
                        cal_err_q   <= cal_errors;                // see RL8
                    end
                end
                default: begin
                    cal_state_q <= servo_od_pkg::CAL_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        rd_val   = 32'h00000000;
        rd_known = 1'b1;
        rd_only  = 1'b1;
        case (od_index)
            servo_od_pkg::IDX_POS_KI: begin
                rd_val  = wr_gain_q[0];
                rd_only = 1'b0;
            end
            servo_od_pkg::IDX_POS_KP: begin
                rd_val  = wr_gain_q[1];
                rd_only = 1'b0;
            end
            servo_od_pkg::IDX_VEL_KI: begin
                rd_val  = wr_gain_q[2];
                rd_only = 1'b0;
            end
            servo_od_pkg::IDX_VEL_KP: begin
                rd_val  = wr_gain_q[3];
                rd_only = 1'b0;
            end
            servo_od_pkg::IDX_TEMPERATURE: begin
                rd_val = {16'h0000, servo_od_pkg::TEMPERATURE_VAL}; // see RL5
            end
            servo_od_pkg::IDX_OV_THRESH: begin
                rd_val = OV_THRESH_FLT;                           // see RL9
            end
            servo_od_pkg::IDX_PWM_FREQ: begin
                rd_val = PWM_FREQ_HZ;                             // see RL6
            end
            servo_od_pkg::IDX_CAL_CMD: begin
                rd_val  = {16'h0000, cal_cmd_q};
                rd_only = 1'b0;
            end
            servo_od_pkg::IDX_CAL_STATUS: begin
                rd_val = {16'h0000, cal_status};                  // see RL14
            end
            servo_od_pkg::IDX_UV_THRESH: begin
                rd_val = UV_THRESH_FLT;                           // see RL10
            end
            servo_od_pkg::IDX_ANALOG_IN: begin
                rd_val = {16'h0000, analog_q};                    // see RL11
            end
            servo_od_pkg::IDX_FAULTS: begin
                rd_val = {16'h0000, fault_word};                  // see RL14
            end
            default: begin
                rd_known = 1'b0;
            end
        endcase
    end

    // a write to a read-only entry changes nothing but is flagged
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            od_rdata_q <= 32'h00000000;
            od_ack_q   <= 1'b0;
            od_err_q   <= 1'b0;
        end else begin
            od_ack_q <= od_rd || od_wr;
            od_err_q <= (od_rd || od_wr) &&
                        (!rd_known || (od_wr && rd_only));        // see RL14
            if (od_rd) begin
                od_rdata_q <= rd_val;
            end
        end
    end

    sequence cal_cmd_s;
        cmd_wr && od_wdata[15:0] == servo_od_pkg::CMD_CALIBRATE
        && cal_state_q == servo_od_pkg::CAL_IDLE;
    endsequence

    sequence cal_pulse_s;
        cal_start_q && !align_start_q ##1 !cal_start_q;
    endsequence

    node_id_reset_a: assert property (@(posedge ref_clk)  // see RL2
        $rose(nrst) |-> node_id_q == servo_od_pkg::NODE_ID_RESET)
        else $error("node id not 0x28 after reset");

    bit_tick_period_a: assert property (@(posedge ref_clk)  // see RL1
        disable iff (!nrst)
        can_bit_tick_q |=> !can_bit_tick_q [*8] ##1 !can_bit_tick_q
        ##1 can_bit_tick_q)
        else $error("bit tick period not ten clocks");

    gain_hold_a: assert property (@(posedge ref_clk)  // see RL3
        disable iff (!nrst)
        en_now && $past(en_now) |-> $stable(pos_kp_q) && $stable(vel_kp_q))
        else $error("gain changed while enabled");

    gain_apply_a: assert property (@(posedge ref_clk)  // see RL15
        disable iff (!nrst)
        od_wr && od_index == servo_od_pkg::IDX_POS_KP ##1 !en_now
        |-> ##1 pos_kp_q == $past(od_wdata, 2))
        else $error("pending gain not applied");

    temp_zero_a: assert property (@(posedge ref_clk)  // see RL5
        disable iff (!nrst)
        od_rd && od_index == servo_od_pkg::IDX_TEMPERATURE
        |=> od_ack_q && od_rdata_q == 32'h00000000)
        else $error("temperature reads nonzero");

    cal_start_a: assert property (@(posedge ref_clk)  // see RL7
        disable iff (!nrst)
        cal_cmd_s |=> cal_pulse_s)
        else $error("calibrate command did not start");

    ov_fault_a: assert property (@(posedge ref_clk)  // see RL9
        disable iff (!nrst)
        supply_valid |=> ov_fault_q == ($past(supply_mv) > OV_MV)
                      && uv_fault_q == ($past(supply_mv) < UV_MV))
        else $error("voltage fault wrong");

    analog_upd_a: assert property (@(posedge ref_clk)  // see RL11
        disable iff (!nrst)
        adc_valid ##1 od_rd && od_index == servo_od_pkg::IDX_ANALOG_IN
        && !adc_valid |=> od_rdata_q == {16'h0000, $past(adc_mv, 2)})
        else $error("analog entry stale");

    fault_bits_a: assert property (@(posedge ref_clk)  // see RL12
        disable iff (!nrst)
        od_rd && od_index == servo_od_pkg::IDX_FAULTS
        |=> od_rdata_q == {22'h000000, $past(encoder_fault, 2), 9'h000})
        else $error("fault entry wrong");

    ro_write_a: assert property (@(posedge ref_clk)  // see RL14
        disable iff (!nrst)
        od_wr && od_index == servo_od_pkg::IDX_PWM_FREQ |=> od_err_q)
        else $error("read-only write not refused");

endmodule // servo_od_bank

// ===== servo_od_pkg.sv
/*
 * Constants shared by the servo drive object-dictionary bank: entry
 * indices, field positions, command codes, state encodings and link timing.
 * Assumes a single 10 MHz drive clock.
 */
package servo_od_pkg;

    // object-dictionary indices
    localparam logic [15:0] IDX_POS_KI       = 16'h2020;
    localparam logic [15:0] IDX_POS_KP       = 16'h2022;
    localparam logic [15:0] IDX_VEL_KI       = 16'h2026;
    localparam logic [15:0] IDX_VEL_KP       = 16'h2027;
    localparam logic [15:0] IDX_TEMPERATURE  = 16'h2044;
    localparam logic [15:0] IDX_OV_THRESH    = 16'h20a1;
    localparam logic [15:0] IDX_PWM_FREQ     = 16'h20b2;
    localparam logic [15:0] IDX_CAL_CMD      = 16'h20be;
    localparam logic [15:0] IDX_CAL_STATUS   = 16'h20c0;
    localparam logic [15:0] IDX_UV_THRESH    = 16'h20cf;
    localparam logic [15:0] IDX_ANALOG_IN    = 16'h20f2;
    localparam logic [15:0] IDX_FAULTS       = 16'h603f;

    localparam int          GAIN_N           = 4;
    localparam logic [15:0] GAIN_IDX [0:3]   = '{IDX_POS_KI, IDX_POS_KP,
                                                 IDX_VEL_KI, IDX_VEL_KP};
    localparam logic [3:0]  GAIN_INT_MASK    = 4'h5;
    localparam logic [31:0] GAIN_RESET       = 32'h00000000;

    // network parameters
    localparam logic [7:0]  NODE_ID_RESET    = 8'h28;
    localparam int          CLK_HZ           = 10_000_000;
    localparam int          BIT_RATE_BPS     = 1_000_000;
    localparam int          BIT_CYCLES       = CLK_HZ / BIT_RATE_BPS;
    localparam logic [3:0]  BIT_CNT_MAX      = 4'(BIT_CYCLES - 1);

    // status word: operation enabled is bits 2:0 set, bits 3 and 6 clear
    localparam logic [15:0] SW_ENABLED_MASK  = 16'h004f;
    localparam logic [15:0] SW_ENABLED_VAL   = 16'h0007;

    // calibration command codes and status error field
    localparam logic [15:0] CMD_NONE         = 16'h0000;
    localparam logic [15:0] CMD_CALIBRATE    = 16'h0001;
    localparam logic [15:0] CMD_ALIGN        = 16'h0002;
    localparam int          CAL_ERR_LSB      = 8;
    localparam int          CAL_ERR_MSB      = 11;
    localparam logic [3:0]  CAL_ERR_RESET    = 4'h0;

    localparam int          FAULT_ENC_BIT    = 9;
    localparam logic [15:0] TEMPERATURE_VAL  = 16'h0000;

    // single-precision exponent field
    localparam int          FLT_EXP_LSB      = 23;
    localparam int          FLT_EXP_MSB      = 30;

    typedef enum logic [2:0] {
        CAL_IDLE  = 3'b001,
        CAL_RUN   = 3'b010,
        CAL_ALIGN = 3'b100
    } cal_state_t;

endpackage

// ===== od_master.sv
/*
 * Behavioural network master for the servo object-dictionary bank: issues
 * one entry access per call on the od_* port.
 * Assumes one request per cycle, answered by od_ack_q one cycle later.
 */
`timescale 1ns/1ps

module od_master (
    input  wire logic        ref_clk,
    output logic      [15:0] od_index,
    output logic             od_rd,
    output logic             od_wr,
    output logic      [31:0] od_wdata,
    input  wire logic [31:0] od_rdata_q,
    input  wire logic        od_ack_q,
    input  wire logic        od_err_q
);
    initial begin
        od_index = 16'h0000;
        od_rd    = 1'b0;
        od_wr    = 1'b0;
        od_wdata = 32'h00000000;
    end

    // released index and data lines are inverted so a stale value never passes as held
    task automatic access(input logic wr, input logic [15:0] idx,
                          input logic [31:0] wd, output logic [31:0] rd,
                          output logic er, output logic ok);
        @(negedge ref_clk);
        od_index <= idx;
        od_wdata <= wd; // gains go out unscaled
        od_rd    <= ~wr;
        od_wr    <= wr;
        // ack stands one cycle only, so it is taken mid-cycle
        @(negedge ref_clk);
        ok = od_ack_q;
        rd = od_rdata_q;
        er = od_err_q;
        od_rd    <= 1'b0;
        od_wr    <= 1'b0;
        od_index <= ~idx;
        od_wdata <= ~wd;
        @(posedge ref_clk);
        #1;
    endtask
endmodule // od_master

// ===== tb_top.sv
/*
 * Self-checking bench for the servo object-dictionary bank.
 * Assumes a 10 MHz ref_clk and the master model in od_master.sv.
 */
`timescale 1ns/1ps

module tb_top;
    logic        ref_clk, nrst, node_id_load, supply_valid, adc_valid;
    logic        encoder_fault, cal_done, od_rd, od_wr;
    logic [7:0]  node_id_new, node_id_q;
    logic [15:0] statusword, supply_mv, adc_mv, od_index;
    logic [3:0]  cal_errors, e;
    logic [31:0] od_wdata, od_rdata_q, pos_ki_q, pos_kp_q, vel_ki_q;
    logic [31:0] vel_kp_q, lfsr_q, v, r, old;
    logic        od_ack_q, od_err_q, can_bit_tick_q, drive_enabled_q;
    logic        ov_fault_q, uv_fault_q, cal_start_q, align_start_q, er;
    int          errors, cmp_count, start_cnt, align_cnt, n;
    logic [15:0] ro_idx [0:6];
    logic [15:0] mv_tab [0:4];

    servo_od_bank u_servo_od_bank (
        .ref_clk(ref_clk), .nrst(nrst), .od_index(od_index), .od_rd(od_rd),
        .od_wr(od_wr), .od_wdata(od_wdata), .od_rdata_q(od_rdata_q),
        .od_ack_q(od_ack_q), .od_err_q(od_err_q),
        .node_id_load(node_id_load), .node_id_new(node_id_new),
        .node_id_q(node_id_q), .can_bit_tick_q(can_bit_tick_q),
        .statusword(statusword), .drive_enabled_q(drive_enabled_q),
        .pos_ki_q(pos_ki_q), .pos_kp_q(pos_kp_q), .vel_ki_q(vel_ki_q),
        .vel_kp_q(vel_kp_q), .supply_valid(supply_valid),
        .supply_mv(supply_mv), .ov_fault_q(ov_fault_q),
        .uv_fault_q(uv_fault_q), .adc_valid(adc_valid), .adc_mv(adc_mv),
        .encoder_fault(encoder_fault), .cal_start_q(cal_start_q),
        .align_start_q(align_start_q), .cal_done(cal_done),
        .cal_errors(cal_errors));

    od_master u_od_master (
        .ref_clk(ref_clk), .od_index(od_index), .od_rd(od_rd),
        .od_wr(od_wr), .od_wdata(od_wdata), .od_rdata_q(od_rdata_q),
        .od_ack_q(od_ack_q), .od_err_q(od_err_q));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (cal_start_q === 1'b1) start_cnt++;
        if (align_start_q === 1'b1) align_cnt++;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic nxt(output logic [31:0] x);
        lfsr_q = {lfsr_q[30:0],
                  lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        x = lfsr_q;
    endtask

    task automatic xfer(input logic w, input logic [15:0] idx,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic err);
        logic ok;
        u_od_master.access(w, idx, d, q, err, ok);
        check(32'(ok), 32'h1);
    endtask

    task automatic done(input logic [3:0] x);
        @(negedge ref_clk);
        cal_done   <= 1'b1;
        cal_errors <= x;
        @(negedge ref_clk);
        cal_done   <= 1'b0;
        cal_errors <= ~x;
    endtask

    // integral gains: exponent reduced by the sample shift, tiny ones flushed
    function automatic logic [31:0] gain_exp(int i, logic [31:0] x);
        if (!servo_od_pkg::GAIN_INT_MASK[i]) return x;
        if (x[30:23] <= 8'h0d) return 32'h00000000;
        return {x[31], x[30:23] - 8'h0d, x[22:0]};
    endfunction

    function automatic logic [31:0] gain_out(int i);
        case (i)
            0: return pos_ki_q;
            1: return pos_kp_q;
            2: return vel_ki_q;
            default: return vel_kp_q;
        endcase
    endfunction

    initial begin
        #500000;
        errors++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        {nrst, node_id_load, supply_valid, adc_valid} = 4'h0;
        {encoder_fault, cal_done, cal_errors} = 6'h00;
        {node_id_new, statusword, supply_mv, adc_mv} = 56'h0;
        errors = 0; cmp_count = 0; start_cnt = 0; align_cnt = 0;
        lfsr_q = 32'h46cfedca;
        ro_idx = '{servo_od_pkg::IDX_TEMPERATURE, servo_od_pkg::IDX_OV_THRESH,
                   servo_od_pkg::IDX_PWM_FREQ, servo_od_pkg::IDX_CAL_STATUS,
                   servo_od_pkg::IDX_UV_THRESH, servo_od_pkg::IDX_ANALOG_IN,
                   servo_od_pkg::IDX_FAULTS};
        mv_tab = '{16'h90d1, 16'h90d0, 16'h2327, 16'h2328, 16'h5000};
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) nrst <= 1'b1;
        @(posedge ref_clk) #1;
        check(32'(node_id_q), 32'h28);
        for (int i = 0; i < 4; i++) check(gain_out(i), 32'h0);
        nxt(v);
        @(negedge ref_clk) {node_id_load, node_id_new} <= {1'b1, v[7:0]};
        @(negedge ref_clk) node_id_load <= 1'b0;
        check(32'(node_id_q), 32'(v[7:0]));
        $display("test reset and node id done");

        for (n = 0; n < 20 && can_bit_tick_q !== 1'b1; n++)
            @(posedge ref_clk) #1;
        n = 0;
        do begin @(posedge ref_clk) #1; n++; end
        while (can_bit_tick_q !== 1'b1 && n < 20);
        check(n, 10);
        $display("test bit rate done");

        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, ro_idx[i], 32'h0, old, er);
            nxt(v);
            xfer(1'b1, ro_idx[i], v, r, er);
            check(32'(er), 32'h1);
            xfer(1'b0, ro_idx[i], 32'h0, r, er);
            check(r, old);
        end
        xfer(1'b0, servo_od_pkg::IDX_TEMPERATURE, 32'h0, r, er);
        check(32'(r[15:0]), 32'h0);
        xfer(1'b0, servo_od_pkg::IDX_PWM_FREQ, 32'h0, r, er);
        check(r, 32'h00004e20);
        xfer(1'b0, servo_od_pkg::IDX_OV_THRESH, 32'h0, r, er);
        check(r, 32'h42140000);
        xfer(1'b0, servo_od_pkg::IDX_UV_THRESH, 32'h0, r, er);
        check(r, 32'h41100000);
        xfer(1'b0, 16'h1234, 32'h0, r, er);
        check(32'(er), 32'h1);
        $display("test read-only entries done");

        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk) statusword <= (i == 1) ? 16'h000f : 16'h0000;
            nxt(v);
            if (i == 0) v[30:23] = 8'h0d;
            xfer(1'b1, servo_od_pkg::GAIN_IDX[i], v, r, er);
            check(32'(er), 32'h0);
            @(posedge ref_clk) #1;
            check(gain_out(i), gain_exp(i, v));
            check(32'(drive_enabled_q), 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk) statusword <= 16'h0007;
            old = gain_out(i);
            nxt(v);
            xfer(1'b1, servo_od_pkg::GAIN_IDX[i], v, r, er);
            repeat (3) @(posedge ref_clk) #1;
            check(gain_out(i), old);
            check(32'(drive_enabled_q), 32'h1);
            xfer(1'b0, servo_od_pkg::GAIN_IDX[i], 32'h0, r, er);
            check(r, v);
            @(negedge ref_clk) statusword <= 16'h0000;
            repeat (2) @(posedge ref_clk) #1;
            check(gain_out(i), gain_exp(i, v));
        end
        $display("test gains done");

        for (int i = 0; i < 5; i++) begin
            @(negedge ref_clk) {supply_valid, supply_mv} <= {1'b1, mv_tab[i]};
            @(negedge ref_clk) {supply_valid, supply_mv} <= {1'b0, ~mv_tab[i]};
            @(negedge ref_clk);
            check(32'(ov_fault_q), 32'(mv_tab[i] > 16'h90d0));
            check(32'(uv_fault_q), 32'(mv_tab[i] < 16'h2328));
        end
        for (int i = 0; i < 3; i++) begin
            nxt(v);
            @(negedge ref_clk) {adc_valid, adc_mv} <= {1'b1, v[15:0]};
            @(negedge ref_clk) {adc_valid, adc_mv} <= {1'b0, ~v[15:0]};
            xfer(1'b0, servo_od_pkg::IDX_ANALOG_IN, 32'h0, r, er);
            check(32'(r[15:0]), 32'(v[15:0]));
        end
        for (int i = 1; i >= 0; i--) begin
            @(negedge ref_clk) encoder_fault <= i[0];
            xfer(1'b0, servo_od_pkg::IDX_FAULTS, 32'h0, r, er);
            check(32'(r[15:0]), i[0] ? 32'h200 : 32'h0);
        end
        $display("test supply, analog and faults done");

        xfer(1'b1, servo_od_pkg::IDX_CAL_CMD, 32'h1, r, er);
        check(start_cnt, 1);
        xfer(1'b1, servo_od_pkg::IDX_CAL_CMD, 32'h2, r, er);
        check(align_cnt, 0);
        nxt(v);
        e = v[3:0];
        done(e);
        xfer(1'b0, servo_od_pkg::IDX_CAL_STATUS, 32'h0, r, er);
        check(32'(r[15:0]), {20'h0, e, 8'h00});
        xfer(1'b0, servo_od_pkg::IDX_CAL_CMD, 32'h0, r, er);
        check(32'(r[15:0]), 32'h0);
        xfer(1'b1, servo_od_pkg::IDX_CAL_CMD, 32'h2, r, er);
        check(align_cnt, 1);
        xfer(1'b0, servo_od_pkg::IDX_CAL_STATUS, 32'h0, r, er);
        check(32'(r[15:0]), 32'h0);
        done(~e);
        xfer(1'b0, servo_od_pkg::IDX_CAL_STATUS, 32'h0, r, er);
        check(32'(r[15:0]), {20'h0, ~e, 8'h00});
        xfer(1'b1, servo_od_pkg::IDX_CAL_CMD, 32'h0, r, er);
        xfer(1'b1, servo_od_pkg::IDX_CAL_CMD, 32'h3, r, er);
        check(start_cnt + align_cnt, 2);
        xfer(1'b0, servo_od_pkg::IDX_CAL_CMD, 32'h0, r, er);
        check(32'(r[15:0]), 32'h3);
        $display("test calibration done");
        complete_run();
    end
endmodule // tb_top
